// file: design/flash_sp_core_end.sv
// Core-side end: AXI4-Lite registers that drive the sequencer link
//
// The address map and the AXI4-Lite register port were decided locally.
`include "flash_sp_cfg.svh"
`default_nettype none
module flash_sp_core_end (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [`AXI_DW-1:0] wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [`AXI_DW-1:0]      rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  flash_sp_if.core                link
);
  logic [`AXI_AW-1:0]  aw_addr_q;
  logic                aw_have_q;
  logic [`AXI_DW-1:0]  w_data_q;
  logic                w_have_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  logic [`AXI_DW-1:0]  rdata_q;
  logic [`PTR_W-1:0]   ptr_q;
  logic [`WORD_W-1:0]  data_q;
  logic [`FADDR_W-1:0] rd_addr_q;
  logic                ctrl_wr_q;
  logic [`CTRL_W-1:0]  ctrl_wdata_q;
  logic                spm_q;
  logic                pend_spm_q;
  logic                ee_q;
  logic                fire;
  logic                ar_go;

  // A halted core issues nothing, so writes wait out the stall
  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign fire    = aw_have_q && w_have_q && !bvalid_q && !link.stall &&
                   !pend_spm_q;
  assign arready = !rvalid_q;
  assign ar_go   = arvalid && arready;

  // Address and data are caught independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
    end
    else if (fire)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
      end
    end
  end

  // Register writes and the one-cycle strobes they launch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_q        <= '0;
      data_q       <= '0;
      rd_addr_q    <= '0;
      ctrl_wr_q    <= 1'b0;
      ctrl_wdata_q <= '0;
      spm_q        <= 1'b0;
      pend_spm_q   <= 1'b0;
      ee_q         <= 1'b0;
    end
    else
    begin
      ctrl_wr_q  <= 1'b0;
      ee_q       <= 1'b0;
      // Combined write puts the instruction one cycle after the control
      spm_q      <= pend_spm_q;
      pend_spm_q <= 1'b0;
      if (fire)
      begin
        case (aw_addr_q)
          `OFF_CTRL, `OFF_CTRL_GO:
          begin
            ctrl_wr_q    <= 1'b1;
            ctrl_wdata_q <= w_data_q[`CTRL_W-1:0];
            pend_spm_q   <= (aw_addr_q == `OFF_CTRL_GO);
          end
          `OFF_PTR:    ptr_q     <= w_data_q[`PTR_W-1:0];
          `OFF_DATA:   data_q    <= w_data_q[`WORD_W-1:0];
          `OFF_RDADDR: rd_addr_q <= w_data_q[`FADDR_W-1:0];
          `OFF_CMD:
          begin
            spm_q <= w_data_q[`CMD_SPM_BIT];
            ee_q  <= w_data_q[`CMD_EE_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (fire)
    begin
      bvalid_q <= 1'b1;
      case (aw_addr_q)
        `OFF_CTRL, `OFF_CTRL_GO, `OFF_PTR, `OFF_DATA, `OFF_RDADDR,
        `OFF_CMD: bresp_q <= `RESP_OKAY;
        default:  bresp_q <= `RESP_SLVERR;
      endcase
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // Read channel; reads stay open during a stall so status can be polled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= '0;
    end
    else if (ar_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= '0;
      case (araddr)
        `OFF_CTRL:   rdata_q[`CTRL_W-1:0]  <= link.ctrl_rdata;
        `OFF_PTR:    rdata_q[`PTR_W-1:0]   <= ptr_q;
        `OFF_DATA:   rdata_q[`WORD_W-1:0]  <= data_q;
        `OFF_RDADDR: rdata_q[`FADDR_W-1:0] <= rd_addr_q;
        `OFF_RDDATA: rdata_q[`WORD_W-1:0]  <= link.rd_data;
        `OFF_STATUS: rdata_q[0]            <= link.stall;
        `OFF_CMD, `OFF_CTRL_GO: ;
        default:     rresp_q <= `RESP_SLVERR;
      endcase
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign rvalid          = rvalid_q;
  assign rresp           = rresp_q;
  assign rdata           = rdata_q;
  assign link.ctrl_wr    = ctrl_wr_q;
  assign link.ctrl_wdata = ctrl_wdata_q;
  assign link.store_program_instruction        = spm_q;
  assign link.ee_write   = ee_q;
  assign link.ptr        = ptr_q;
  assign link.data_pair  = data_q;
  assign link.rd_addr    = rd_addr_q;
endmodule
`default_nettype wire

// file: design/flash_sp_cfg.svh
// Constants for the flash self-program sequencer and its core-side end
`ifndef FLASH_SP_CFG_SVH
`define FLASH_SP_CFG_SVH
`define CTRL_W        8
`define CMD_W         5
`define BIT_EN        0
`define BIT_ERS       1
`define BIT_WRT       2
`define BIT_CLEAR_PAGE_BUFFER_BIT      4
`define CMD_LOAD      5'h01
`define CMD_ERASE     5'h03
`define CMD_WRITE     5'h05
`define CMD_CLEAR     5'h11
`define WIN_W         3
`define WIN_CYCLES    3'h4
`define WIN_NONE      3'h0
`define PTR_W         16
`define WORD_LSB      1
`define WORD_BITS     4
`define PAGE_LSB      5
`define PAGE_BITS     5
`define FADDR_W       9
`define PAGE_WORDS    16
`define FLASH_WORDS   512
`define WORD_W        16
`define ERASED        16'hFFFF
`define PROG_TIME_NS  3700000
`define CLK_PERIOD_NS 8
`define CNT_W         20
`define AXI_AW        8
`define AXI_DW        32
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define OFF_CTRL      8'h00
`define OFF_PTR       8'h04
`define OFF_DATA      8'h08
`define OFF_CMD       8'h0C
`define OFF_RDADDR    8'h10
`define OFF_RDDATA    8'h14
`define OFF_STATUS    8'h18
`define OFF_CTRL_GO   8'h1C
`define CMD_SPM_BIT   0
`define CMD_EE_BIT    1
`endif

// file: design/flash_sp_pkg.sv
// Types used by the sequencer; the core-side end does not import them
`default_nettype none
package flash_sp_pkg;
  // Array operation in progress
  typedef enum logic [1:0]
  {
    OP_IDLE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10
  } op_t;
endpackage
`default_nettype wire

// file: design/flash_sp_if.sv
// Link between the processor core end and the self-program sequencer
`include "flash_sp_cfg.svh"
`default_nettype none
interface flash_sp_if;
  logic                ctrl_wr;
  logic [`CTRL_W-1:0]  ctrl_wdata;
  logic [`CTRL_W-1:0]  ctrl_rdata;
  logic                store_program_instruction;
  logic [`PTR_W-1:0]   ptr;
  logic [`WORD_W-1:0]  data_pair;
  logic                ee_write;
  logic                stall;
  logic [`FADDR_W-1:0] rd_addr;
  logic [`WORD_W-1:0]  rd_data;
  modport seq
  (
    input  ctrl_wr, ctrl_wdata, store_program_instruction, ptr, data_pair, ee_write, rd_addr,
    output ctrl_rdata, stall, rd_data
  );
  modport core
  (
    output ctrl_wr, ctrl_wdata, store_program_instruction, ptr, data_pair, ee_write, rd_addr,
    input  ctrl_rdata, stall, rd_data
  );
endinterface
`default_nettype wire

// file: design/flash_op_timer.sv
// Down-counter that times one flash array erase or write
`include "flash_sp_cfg.svh"
`default_nettype none
module flash_op_timer #(
  parameter int unsigned CYCLES = 462500
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [`CNT_W-1:0] cnt_q;

  // Load on start, count to one, then signal done for one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (start)
      cnt_q <= CYCLES[`CNT_W-1:0];
    else if (cnt_q != '0)
      cnt_q <= cnt_q - `CNT_W'(1);
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == `CNT_W'(1));
endmodule
`default_nettype wire

// file: design/flash_self_program_sequencer.sv
// Self-program sequencer: page buffer, control register, erase and write
`include "flash_sp_cfg.svh"
`default_nettype none
module flash_self_program_sequencer #(
  parameter int unsigned PROG_CYCLES =
    (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  flash_sp_if.seq   link,
  output logic      prog_active
);
  logic [`WORD_W-1:0]     flash_q [`FLASH_WORDS];
  logic [`WORD_W-1:0]     buf_q [`PAGE_WORDS];
  logic [`PAGE_WORDS-1:0] buf_vld_q;
  logic                   en_q;
  logic                   ers_q;
  logic                   wrt_q;
  logic [`WIN_W-1:0]      win_q;
  flash_sp_pkg::op_t      op_q;
  logic [`PAGE_BITS-1:0]  page_q;
  logic [`WORD_W-1:0]     rd_data_q;
  logic [`CMD_W-1:0]      cmd;
  logic                   cmd_ok;
  logic                   spm_go;
  logic                   load_go;
  logic                   start_op;
  logic                   op_done;
  logic                   buf_clr;
  logic [`WORD_BITS-1:0]  widx;
  logic [`PAGE_BITS-1:0]  pidx;

  assign cmd  = link.ctrl_wdata[`CMD_W-1:0];
  assign widx = link.ptr[`WORD_LSB +: `WORD_BITS];
  assign pidx = link.ptr[`PAGE_LSB +: `PAGE_BITS];

  // Only the defined patterns arm anything; writes while busy are dropped
  assign cmd_ok = link.ctrl_wr && (op_q == flash_sp_pkg::OP_IDLE) &&
                  (cmd == `CMD_LOAD || cmd == `CMD_ERASE ||
                   cmd == `CMD_WRITE || cmd == `CMD_CLEAR);

  // An instruction counts only while the four-cycle window is open
  assign spm_go   = link.store_program_instruction && en_q && (win_q != `WIN_NONE) &&
                    (op_q == flash_sp_pkg::OP_IDLE);
  assign load_go  = spm_go && !ers_q && !wrt_q;
  assign start_op = spm_go && (ers_q || wrt_q);

  // Clear sources for the whole buffer
  assign buf_clr = (cmd_ok && cmd == `CMD_CLEAR) ||
                   link.ee_write ||
                   (op_done && op_q == flash_sp_pkg::OP_WRITE);

  flash_op_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_op),
    .busy    (),
    .done    (op_done)
  );

  // Window counter: opened by a defined pattern, closed by use or timeout
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      win_q <= `WIN_NONE;
    else if (cmd_ok)
      win_q <= `WIN_CYCLES;
    else if (spm_go)
      win_q <= `WIN_NONE;
    else if (win_q != `WIN_NONE)
      win_q <= win_q - `WIN_W'(1);
  end

  // Control bits; enable and command bits stay up through an array op
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q  <= 1'b0;
      ers_q <= 1'b0;
      wrt_q <= 1'b0;
    end
    else if (cmd_ok)
    begin
      en_q  <= cmd[`BIT_EN];
      ers_q <= cmd[`BIT_ERS];
      wrt_q <= cmd[`BIT_WRT];
    end
    else if (op_done)
    begin
      en_q  <= 1'b0;
      ers_q <= 1'b0;
      wrt_q <= 1'b0;
    end
    else if (load_go ||
             (win_q == `WIN_W'(1) && !start_op &&
              op_q == flash_sp_pkg::OP_IDLE))
    begin
      en_q  <= 1'b0;
      ers_q <= 1'b0;
      wrt_q <= 1'b0;
    end
  end

  // Operation state; the page is latched at start, other pointer bits unused
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_q   <= flash_sp_pkg::OP_IDLE;
      page_q <= '0;
    end
    else
    begin
      case (op_q)
        flash_sp_pkg::OP_IDLE:
          if (start_op)
          begin
            op_q   <= ers_q ? flash_sp_pkg::OP_ERASE
                            : flash_sp_pkg::OP_WRITE;
            page_q <= pidx;
          end
        flash_sp_pkg::OP_ERASE,
        flash_sp_pkg::OP_WRITE:
          if (op_done)
            op_q <= flash_sp_pkg::OP_IDLE;
        default:
          op_q <= flash_sp_pkg::OP_IDLE;
      endcase
    end
  end

  // Page buffer; valid bits track first writes since the last clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || buf_clr)
    begin
      buf_vld_q <= '0;
      for (int i = 0; i < `PAGE_WORDS; i++)
        buf_q[i] <= `ERASED;
    end
    else if (load_go)
    begin
      buf_vld_q[widx] <= 1'b1;
      // A rewrite merges like a second program pulse: unreliable data
      if (buf_vld_q[widx])
        buf_q[widx] <= buf_q[widx] & link.data_pair;
      else
        buf_q[widx] <= link.data_pair;
    end
  end

  // Array update at the end of the timed operation; no reset, it is
  // the non-volatile store and keeps contents across a system reset
  always_ff @(posedge aclk)
  begin
    if (op_done)
    begin
      for (int i = 0; i < `PAGE_WORDS; i++)
      begin
        if (op_q == flash_sp_pkg::OP_ERASE)
          flash_q[{page_q, i[`WORD_BITS-1:0]}] <= `ERASED;
        else if (op_q == flash_sp_pkg::OP_WRITE)
          // Programming can only clear bits, so an unerased page corrupts
          flash_q[{page_q, i[`WORD_BITS-1:0]}] <=
            flash_q[{page_q, i[`WORD_BITS-1:0]}] & buf_q[i];
      end
    end
  end

  // Registered read port for the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_data_q <= '0;
    else
      rd_data_q <= flash_q[link.rd_addr];
  end

  // Stall covers the whole timed operation
  assign link.stall = (op_q != flash_sp_pkg::OP_IDLE);
  assign prog_active = link.stall;
  assign link.rd_data = rd_data_q;
  assign link.ctrl_rdata = {3'h0, 1'b0, 1'b0, wrt_q, ers_q, en_q};
endmodule
`default_nettype wire

// file: test/flash_sp_assertions.sv
// Concurrent checks on the link between the core end and the sequencer
`include "flash_sp_cfg.svh"
`default_nettype none
module flash_sp_assertions #(
  parameter int unsigned PROG_CYCLES = 20
)(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ctrl_wr,
  input wire logic [`CTRL_W-1:0] ctrl_wdata,
  input wire logic [`CTRL_W-1:0] ctrl_rdata,
  input wire logic               store_program_instruction,
  input wire logic               stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`CNT_W-1:0] stall_cnt_q;

  // Stall length so far; a counter avoids a huge unrolled repetition
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !stall)
      stall_cnt_q <= '0;
    else
      stall_cnt_q <= stall_cnt_q + `CNT_W'(1);
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // A command the sequencer accepts, and the silence that expires it
  sequence armed(logic [`CMD_W-1:0] c);
    ctrl_wr && ctrl_wdata[`CMD_W-1:0] == c && !stall;
  endsequence
  sequence quiet4;
    (!store_program_instruction && !ctrl_wr) [*4];
  endsequence

  erase_start_a: assert property (
    armed(`CMD_ERASE) ##[1:4] store_program_instruction |=> stall)
    else $error("Erase did not halt the core");
  write_start_a: assert property (
    armed(`CMD_WRITE) ##[1:4] store_program_instruction |=> stall)
    else $error("Page write did not halt the core");
  load_no_stall_a: assert property (
    armed(`CMD_LOAD) ##[1:4] store_program_instruction |=> !stall [*2])
    else $error("Buffer load halted the core");
  stall_cause_a: assert property (
    $rose(stall) |-> $past(store_program_instruction))
    else $error("Stall rose without an instruction");
  stall_length_a: assert property (
    $fell(stall) |-> stall_cnt_q == `CNT_W'(PROG_CYCLES))
    else $error("Stall length differs from array time");
  busy_bits_a: assert property (
    stall |-> ctrl_rdata[`BIT_EN] &&
      (ctrl_rdata[`BIT_ERS] ^ ctrl_rdata[`BIT_WRT]))
    else $error("Command bits dropped during operation");
  op_end_clear_a: assert property (
    $fell(stall) |-> ##[0:1] ctrl_rdata == 8'h00)
    else $error("Control bits stayed after operation");
  reserved_zero_a: assert property (
    ctrl_rdata[7:5] == 3'h0 && !ctrl_rdata[3])
    else $error("Reserved control bits not zero");
  load_enable_a: assert property (
    armed(`CMD_LOAD) |=> ctrl_rdata == 8'h01)
    else $error("Enable bit not shown after load arm");
  window_expiry_a: assert property (
    armed(`CMD_LOAD) ##1 quiet4 |-> ##[0:1] ctrl_rdata == 8'h00)
    else $error("Enable bit did not expire");
  undefined_cmd_a: assert property (
    ctrl_wr && !stall && ctrl_rdata == 8'h00 && !(ctrl_wdata[4:0]
      inside {`CMD_LOAD, `CMD_ERASE, `CMD_WRITE, `CMD_CLEAR})
    |=> ctrl_rdata == 8'h00 [*2])
    else $error("Undefined pattern changed control");
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench: both ends joined, driven over AXI4-Lite
`include "flash_sp_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PROG_N = 20;
  logic        aclk = 1'h0;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        prog_active;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [7:0]  bad [4] = '{8'h07, 8'h09, 8'h02, 8'h13};

  flash_sp_if flash_sp_if_inst ();
  flash_self_program_sequencer #(.PROG_CYCLES(PROG_N))
    flash_self_program_sequencer_inst (.aclk, .aresetn,
    .link(flash_sp_if_inst), .prog_active(prog_active));
  flash_sp_core_end flash_sp_core_end_inst (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .link(flash_sp_if_inst));
  flash_sp_assertions #(.PROG_CYCLES(PROG_N)) flash_sp_assertions_inst (
    .aclk, .aresetn, .ctrl_wr(flash_sp_if_inst.ctrl_wr),
    .ctrl_wdata(flash_sp_if_inst.ctrl_wdata),
    .ctrl_rdata(flash_sp_if_inst.ctrl_rdata),
    .store_program_instruction(flash_sp_if_inst.store_program_instruction), .stall(flash_sp_if_inst.stall));

  // 125 MHz system clock
  always #4 aclk = ~aclk;

  // Comparisons, one task per kind of result
  task automatic check_val(input string n, input logic [31:0] e,
                           input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_resp(input string n, input logic [1:0] e,
                            input logic [1:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Samples at the falling edge so nothing races the rising one
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    b_t = 1'h0;
    while (!b_t)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t)
        awvalid <= 1'h0;
      if (w_t)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    // An edge passes so a following call never re-drives bready now
    @(posedge aclk);
    check_resp("bresp", er, r);
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    logic a_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    r_t = 1'h0;
    while (!r_t)
    begin
      @(negedge aclk);
      a_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_t)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    // Same spacing as writes, so rready is driven once per step
    @(posedge aclk);
    check_val("rdata", ed, d);
    check_resp("rresp", er, r);
  endtask

  // Pointer, data, then control with the instruction one cycle later
  task automatic op(input logic [7:0] c, input logic [15:0] p,
                    input logic [15:0] d);
    axi_write(`OFF_PTR, {16'h0, p}, `RESP_OKAY);
    axi_write(`OFF_DATA, {16'h0, d}, `RESP_OKAY);
    axi_write(`OFF_CTRL_GO, {24'h0, c}, `RESP_OKAY);
  endtask
  function automatic logic [15:0] pp(input int pg, input int wd);
    return 16'(pg * 32 + wd * 2);
  endfunction
  task automatic read_flash(input int pg, input int wd,
                            input logic [15:0] e);
    axi_write(`OFF_RDADDR, 32'(pg * 16 + wd), `RESP_OKAY);
    axi_read(`OFF_RDDATA, {16'h0, e}, `RESP_OKAY);
  endtask
  task automatic program_page(input int pg);
    op({3'h0, `CMD_ERASE}, pp(pg, 0), 16'h0);
    op({3'h0, `CMD_WRITE}, pp(pg, 0), 16'h0);
  endtask

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_read(`OFF_CTRL, 32'h0, `RESP_OKAY);
    axi_read(`OFF_STATUS, 32'h0, `RESP_OKAY);
    axi_read(8'h20, 32'h0, `RESP_SLVERR);
    axi_write(`OFF_RDDATA, 32'h0, `RESP_SLVERR);
    // Erase first, then fill in reverse order, then write
    op({3'h0, `CMD_ERASE}, 16'hFC7E, 16'h0);
    axi_read(`OFF_STATUS, 32'h1, `RESP_OKAY);
    check_val("prog_active", 32'h1, {31'h0, prog_active});
    read_flash(3, 5, 16'hFFFF);
    for (int i = 15; i >= 0; i--)
      op({3'h0, `CMD_LOAD}, pp(3, i), 16'hA500 + 16'(i));
    op({3'h0, `CMD_WRITE}, pp(3, 0), 16'h0);
    axi_read(`OFF_STATUS, 32'h1, `RESP_OKAY);
    for (int i = 0; i < 16; i++)
      read_flash(3, i, 16'hA500 + 16'(i));
    program_page(4);
    read_flash(4, 0, 16'hFFFF);
    // Fill before erase; untouched words stay erased
    op({3'h0, `CMD_LOAD}, pp(5, 0), 16'h1234);
    op({3'h0, `CMD_LOAD}, pp(5, 9), 16'h5678);
    program_page(5);
    read_flash(5, 0, 16'h1234);
    read_flash(5, 9, 16'h5678);
    read_flash(5, 1, 16'hFFFF);
    // Undefined patterns must leave page 3 alone
    for (int i = 0; i < 4; i++)
      op(bad[i], pp(3, 0), 16'h0);
    read_flash(3, 0, 16'hA500);
    // Clear bit, EEPROM write, late instruction, double load
    op({3'h0, `CMD_LOAD}, pp(6, 0), 16'h1111);
    axi_write(`OFF_CTRL, 32'h11, `RESP_OKAY);
    op({3'h0, `CMD_LOAD}, pp(6, 1), 16'h2222);
    axi_write(`OFF_CMD, 32'h2, `RESP_OKAY);
    axi_write(`OFF_CTRL, 32'h1, `RESP_OKAY);
    axi_read(`OFF_CTRL, 32'h1, `RESP_OKAY);
    axi_write(`OFF_CMD, 32'h1, `RESP_OKAY);
    axi_read(`OFF_CTRL, 32'h0, `RESP_OKAY);
    op({3'h0, `CMD_LOAD}, pp(6, 2), 16'h0F0F);
    op({3'h0, `CMD_LOAD}, pp(6, 2), 16'hF0F0);
    op({3'h0, `CMD_LOAD}, pp(6, 3), 16'h3C3C);
    program_page(6);
    read_flash(6, 0, 16'hFFFF);
    read_flash(6, 1, 16'hFFFF);
    read_flash(6, 2, 16'h0000);
    read_flash(6, 3, 16'h3C3C);
    // Change one word of page 5, keeping word 9 through the buffer
    op({3'h0, `CMD_LOAD}, pp(5, 9), 16'h5678);
    op({3'h0, `CMD_LOAD}, pp(5, 0), 16'h1034);
    program_page(5);
    read_flash(5, 9, 16'h5678);
    read_flash(5, 0, 16'h1034);
    // Reset in mid-run: the buffer is lost, the array is kept
    op({3'h0, `CMD_LOAD}, pp(7, 0), 16'h7777);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_read(`OFF_CTRL, 32'h0, `RESP_OKAY);
    program_page(7);
    read_flash(7, 0, 16'hFFFF);
    read_flash(6, 3, 16'h3C3C);
    final_report();
  end
endmodule
`default_nettype wire
